/* rtl/idstore_pkg.sv */
// Package for the identity store and power condition block.
// Assumes a 25 MHz system clock and an AXI4-Lite register bus.
package idstore_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int SEC_MS = 1000;
  localparam int BANNER_MAX = 47;
  localparam int UID_MAX = 15;
  localparam int HWADDR_SHORT = 6;
  localparam int HWADDR_LONG = 12;
  localparam int USER_BYTES = 256;
  localparam int WR_MAX = 8;
  localparam int RD_PER_LINE = 8;
  localparam int VOLT_MIN_DV = 10;
  localparam int VOLT_MAX_DV = 250;
  localparam int DROP_MIN_DV = 1;
  localparam int DROP_MAX_DV = 99;
  localparam int DROP_MS_MIN = 1;
  localparam int DROP_MS_MAX = 100;
  localparam int PROTO_SLOTS = 64;
  // Register byte addresses
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_SLEEP_V = 12'h008;
  localparam logic [11:0] A_SLEEP_T = 12'h00C;
  localparam logic [11:0] A_WAKE_V = 12'h010;
  localparam logic [11:0] A_WAKE_T = 12'h014;
  localparam logic [11:0] A_VBAT = 12'h018;
  localparam logic [11:0] A_UID_LEN = 12'h01C;
  localparam logic [11:0] A_HW_LEN = 12'h020;
  localparam logic [11:0] A_BAN_LEN = 12'h024;
  localparam logic [11:0] A_DSC_LEN = 12'h028;
  localparam logic [11:0] A_PROTO = 12'h02C;
  localparam logic [11:0] A_WR_CNT = 12'h030;
  localparam logic [11:0] A_BANNER = 12'h100;
  localparam logic [11:0] A_DESC = 12'h200;
  localparam logic [11:0] A_UID = 12'h300;
  localparam logic [11:0] A_HWADDR = 12'h380;
  localparam logic [11:0] A_USER = 12'h400;
  // Control bits
  localparam int C_SLP_UART = 0;
  localparam int C_SLP_BUS = 1;
  localparam int C_SLP_IGN = 2;
  localparam int C_WK_UART = 3;
  localparam int C_WK_BUS = 4;
  localparam int C_WK_IGN = 5;
  localparam logic [31:0] CTRL_RST = 32'h0000_0010;
  localparam logic [7:0] SLEEP_V_RST = 8'h00;
  localparam logic [15:0] SLEEP_T_RST = 16'h0001;
  localparam logic [7:0] WAKE_V_RST = 8'h28;
  localparam logic [6:0] WAKE_T_RST = 7'h14;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [7:0] NOT_SET_CHAR = 8'h3F;
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_SLEEP = 2'b01
  } pwr_t;
endpackage : idstore_pkg

/* rtl/identity_store_power_commands.sv */
// Identity strings, one-time identifiers, user area and sleep/wake logic.
// Assumes an AXI4-Lite master on aclk; activity inputs synchronous to aclk.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module identity_store_power_commands
  import idstore_pkg::*;
#(
  parameter int SILENCE_CYCLES = 25000000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_activity,
  input wire logic bus_activity,
  input wire logic ignition_sense,
  input wire logic [7:0] battery_dv,
  output logic sleep_state
);
  // Storage: strings and user area live in their own arrays
  logic [7:0] banner_mem [0:BANNER_MAX-1];
  logic [7:0] desc_mem [0:BANNER_MAX-1];
  logic [7:0] uid_mem [0:UID_MAX-1];
  logic [7:0] hw_mem [0:HWADDR_LONG-1];
  logic [7:0] user_mem [0:USER_BYTES-1];
  logic [5:0] banner_len, desc_len;
  logic [3:0] uid_len, hw_len;
  logic uid_locked, hw_locked;
  logic [31:0] ctrl;
  logic [7:0] sleep_v, wake_v;
  logic [15:0] sleep_t;
  logic [6:0] wake_t;
  logic [63:0] proto_defined, proto_linked;
  logic [15:0] wr_count;
  pwr_t pwr;
  logic ign_at_sleep;
  logic [7:0] vbat_ref;

  // AXI write path: address and data taken in either order
  logic aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_ok;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Decode: string areas take one character per word, low byte
  logic [11:0] wa;
  logic [7:0] wbyte;
  assign wa = aw_addr;
  assign wbyte = w_data[7:0];
  always_comb begin
    wr_ok = 1'b1;
    if (wa >= A_BANNER && wa < A_BANNER + 12'(4 * BANNER_MAX)) wr_ok = 1'b1;
    else if (wa >= A_DESC && wa < A_DESC + 12'(4 * BANNER_MAX)) wr_ok = 1'b1;
    else if (wa >= A_UID && wa < A_UID + 12'(4 * UID_MAX)) wr_ok = !uid_locked;
    else if (wa >= A_HWADDR && wa < A_HWADDR + 12'(4 * HWADDR_LONG)) wr_ok = !hw_locked;
    else if (wa >= A_USER) wr_ok = 1'b1;
    else if (wa == A_UID_LEN) wr_ok = !uid_locked && w_data <= 32'(UID_MAX);
    else if (wa == A_HW_LEN) begin
      wr_ok = !hw_locked && (w_data == 32'(HWADDR_SHORT) || w_data == 32'(HWADDR_LONG));
    end
    else if (wa == A_BAN_LEN || wa == A_DSC_LEN) wr_ok = w_data <= 32'(BANNER_MAX);
    else if (wa == A_SLEEP_V) begin
      wr_ok = w_data >= 32'(VOLT_MIN_DV) && w_data <= 32'(VOLT_MAX_DV);
    end
    else if (wa == A_WAKE_V) begin
      wr_ok = w_data >= 32'(DROP_MIN_DV) && w_data <= 32'(DROP_MAX_DV);
    end
    else if (wa == A_SLEEP_T) wr_ok = w_data[31:16] == 16'h0000 && w_data[15:0] != 16'h0000;
    else if (wa == A_WAKE_T) begin
      wr_ok = w_data >= 32'(DROP_MS_MIN) && w_data <= 32'(DROP_MS_MAX);
    end
    else if (wa == A_CTRL || wa == A_PROTO) wr_ok = 1'b1;
    else wr_ok = 1'b0;
  end

  logic [9:0] widx;
  assign widx = wa[11:2];

  // String and identifier storage
  always_ff @(posedge aclk) begin
    if (do_write && wr_ok && w_strb[0]) begin
      if (wa >= A_BANNER && wa < A_BANNER + 12'(4 * BANNER_MAX))
        banner_mem[6'(widx - 10'(A_BANNER >> 2))] <= wbyte;
      else if (wa >= A_DESC && wa < A_DESC + 12'(4 * BANNER_MAX))
        desc_mem[6'(widx - 10'(A_DESC >> 2))] <= wbyte;
      else if (wa >= A_UID && wa < A_UID + 12'(4 * UID_MAX))
        uid_mem[4'(widx - 10'(A_UID >> 2))] <= wbyte;
      else if (wa >= A_HWADDR && wa < A_HWADDR + 12'(4 * HWADDR_LONG))
        hw_mem[4'(widx - 10'(A_HWADDR >> 2))] <= wbyte;
    end
  end

  // User area: a write word carries up to four bytes at consecutive positions
  logic [7:0] upos;
  assign upos = 8'(widx - 10'(A_USER >> 2));
  always_ff @(posedge aclk) begin
    if (do_write && wr_ok && wa >= A_USER) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb[i]) user_mem[8'(upos + 8'(i))] <= w_data[8*i +: 8];
      end
    end
  end

  // Lengths and one-time locks; writing a length commits and locks the identifier
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      banner_len <= 6'h00;
      desc_len <= 6'h00;
      uid_len <= 4'h0;
      hw_len <= 4'h0;
      uid_locked <= 1'b0;
      hw_locked <= 1'b0;
      wr_count <= 16'h0000;
    end else if (do_write && wr_ok) begin
      if (wa == A_BAN_LEN) banner_len <= w_data[5:0];
      if (wa == A_DSC_LEN) desc_len <= w_data[5:0];
      if (wa == A_UID_LEN) begin
        uid_len <= w_data[3:0];
        uid_locked <= 1'b1;
      end
      if (wa == A_HW_LEN) begin
        hw_len <= w_data[3:0];
        hw_locked <= 1'b1;
      end
      // No wear leveling; count lets software police its write budget
      if (wa >= A_USER) wr_count <= wr_count + 16'h0001;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RST;
      sleep_v <= SLEEP_V_RST;
      sleep_t <= SLEEP_T_RST;
      wake_v <= WAKE_V_RST;
      wake_t <= WAKE_T_RST;
      proto_defined <= 64'h0;
      proto_linked <= 64'h0;
    end else if (do_write && wr_ok) begin
      if (wa == A_CTRL) ctrl <= w_data;
      if (wa == A_SLEEP_V) sleep_v <= w_data[7:0];
      if (wa == A_SLEEP_T) sleep_t <= w_data[15:0];
      if (wa == A_WAKE_V) wake_v <= w_data[7:0];
      if (wa == A_WAKE_T) wake_t <= w_data[6:0];
      // Slot number, defined flag and wake-sequence link per write
      if (wa == A_PROTO) begin
        proto_defined[w_data[5:0]] <= w_data[8];
        proto_linked[w_data[5:0]] <= w_data[9];
      end
    end
  end

  // Read path; answers one cycle after the address is taken
  logic [31:0] rd_val;
  logic rd_ok;
  logic [11:0] ra;
  logic [9:0] ridx;
  logic [7:0] rpos;
  assign ra = s_axi_araddr;
  assign ridx = ra[11:2];
  assign rpos = 8'(ridx - 10'(A_USER >> 2));
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (ra == A_CTRL) rd_val = ctrl;
    else if (ra == A_STATUS) begin
      rd_val = {26'h0, ign_at_sleep, hw_len == 4'h0, hw_locked, uid_locked, 1'b0, pwr[0]};
    end
    else if (ra == A_SLEEP_V) rd_val = {24'h0, sleep_v};
    else if (ra == A_SLEEP_T) rd_val = {16'h0, sleep_t};
    else if (ra == A_WAKE_V) rd_val = {24'h0, wake_v};
    else if (ra == A_WAKE_T) rd_val = {25'h0, wake_t};
    else if (ra == A_VBAT) rd_val = {24'h0, battery_dv};
    else if (ra == A_UID_LEN) rd_val = {28'h0, uid_len};
    else if (ra == A_HW_LEN) rd_val = {28'h0, hw_len};
    else if (ra == A_BAN_LEN) rd_val = {26'h0, banner_len};
    else if (ra == A_DSC_LEN) rd_val = {26'h0, desc_len};
    else if (ra == A_WR_CNT) rd_val = {16'h0, wr_count};
    else if (ra == A_PROTO) rd_val = {30'h0, proto_linked[0], proto_defined[0]};
    else if (ra >= A_BANNER && ra < A_BANNER + 12'(4 * BANNER_MAX))
      rd_val = {24'h0, banner_mem[6'(ridx - 10'(A_BANNER >> 2))]};
    else if (ra >= A_DESC && ra < A_DESC + 12'(4 * BANNER_MAX))
      rd_val = {24'h0, desc_mem[6'(ridx - 10'(A_DESC >> 2))]};
    else if (ra >= A_UID && ra < A_UID + 12'(4 * UID_MAX))
      rd_val = {24'h0, uid_mem[4'(ridx - 10'(A_UID >> 2))]};
    else if (ra >= A_HWADDR && ra < A_HWADDR + 12'(4 * HWADDR_LONG)) begin
      // Unset address reads as a question mark character
      if (hw_len == 4'h0) rd_val = {24'h0, NOT_SET_CHAR};
      else rd_val = {24'h0, hw_mem[4'(ridx - 10'(A_HWADDR >> 2))]};
    end
    else if (ra >= A_USER) begin
      for (int i = 0; i < 4; i++) rd_val[8*i +: 8] = user_mem[8'(rpos + 8'(i))];
    end
    else rd_ok = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Millisecond tick shared by the voltage timers
  logic [14:0] ms_div;
  logic ms_tick;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_div <= 15'h0000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= ms_div == 15'(MS_CYCLES - 1);
      ms_div <= (ms_div == 15'(MS_CYCLES - 1)) ? 15'h0000 : ms_div + 15'h0001;
    end
  end

  // Silence counters
  logic [31:0] uart_quiet, bus_quiet;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uart_quiet <= 32'h0;
      bus_quiet <= 32'h0;
    end else begin
      uart_quiet <= serial_activity ? 32'h0 : (uart_quiet == 32'(SILENCE_CYCLES) ?
        uart_quiet : uart_quiet + 32'h1);
      bus_quiet <= bus_activity ? 32'h0 : (bus_quiet == 32'(SILENCE_CYCLES) ?
        bus_quiet : bus_quiet + 32'h1);
    end
  end

  // Low-voltage sleep timer in seconds, restarted when the voltage recovers
  logic low_v;
  logic [9:0] low_ms;
  logic [15:0] low_sec;
  assign low_v = sleep_v != 8'h00 && battery_dv < sleep_v;
  always_ff @(posedge aclk) begin
    if (!aresetn || !low_v || pwr != PWR_RUN) begin
      low_ms <= 10'h000;
      low_sec <= 16'h0000;
    end else if (ms_tick && low_sec != sleep_t) begin
      low_ms <= (low_ms == 10'(SEC_MS - 1)) ? 10'h000 : low_ms + 10'h001;
      if (low_ms == 10'(SEC_MS - 1)) low_sec <= low_sec + 16'h0001;
    end
  end

  // Voltage-drop wake timer in ms against the level held at sleep entry
  logic drop_v;
  logic [6:0] drop_ms;
  assign drop_v = vbat_ref > battery_dv && (vbat_ref - battery_dv) > wake_v;
  always_ff @(posedge aclk) begin
    if (!aresetn || !drop_v || pwr != PWR_SLEEP) drop_ms <= 7'h00;
    else if (ms_tick && drop_ms <= wake_t) drop_ms <= drop_ms + 7'h01;
  end

  // Sleep/wake state machine
  logic go_sleep, go_wake;
  assign go_sleep = (ctrl[C_SLP_UART] && uart_quiet == 32'(SILENCE_CYCLES))
    || (ctrl[C_SLP_BUS] && bus_quiet == 32'(SILENCE_CYCLES))
    || (ctrl[C_SLP_IGN] && !ignition_sense)
    || (low_v && low_sec == sleep_t);
  assign go_wake = (ctrl[C_WK_UART] && serial_activity)
    || (ctrl[C_WK_BUS] && bus_activity)
    || (ctrl[C_WK_IGN] && ignition_sense != ign_at_sleep)
    || (drop_ms > wake_t);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr <= PWR_RUN;
      sleep_state <= 1'b0;
      ign_at_sleep <= 1'b0;
      vbat_ref <= 8'h00;
    end else begin
      case (pwr)
        PWR_RUN: begin
          if (go_sleep) begin
            pwr <= PWR_SLEEP;
            sleep_state <= 1'b1;
            ign_at_sleep <= ignition_sense;
            vbat_ref <= battery_dv;
          end
        end
        PWR_SLEEP: begin
          if (go_wake) begin
            pwr <= PWR_RUN;
            sleep_state <= 1'b0;
          end
        end
        default: pwr <= PWR_RUN;
      endcase
    end
  end

  // A committed one-time identifier unlocks only on reset
  uid_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    uid_locked |=> uid_locked)
    else $error("identifier lock dropped");
  hw_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hw_locked |-> (hw_len == 4'(HWADDR_SHORT) || hw_len == 4'(HWADDR_LONG)))
    else $error("hardware address length illegal");
  ign_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pwr == PWR_SLEEP && ctrl[C_WK_IGN] && ignition_sense != ign_at_sleep) |=> !sleep_state)
    else $error("ignition wake missed");
  uart_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pwr == PWR_SLEEP && ctrl[C_WK_UART] && serial_activity) |=> pwr == PWR_RUN)
    else $error("serial wake missed");
  bus_sleep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pwr == PWR_RUN && ctrl[C_SLP_BUS] && bus_quiet == 32'(SILENCE_CYCLES)) |=> sleep_state)
    else $error("bus silence sleep missed");
  low_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !low_v |=> low_sec == 16'h0000)
    else $error("low voltage timer not restarted");
  drop_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pwr == PWR_SLEEP && drop_ms > wake_t) |=> !sleep_state)
    else $error("drop wake missed");
  wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("write not answered");
endmodule : identity_store_power_commands

/* sim/axi_host_model.sv */
// AXI4-Lite host model issuing register commands on behalf of the bench.
// Assumes a slave on aclk; tasks are called one at a time from one process.
`timescale 1ns/1ps
module axi_host_model (
  input wire logic aclk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Starts one edge after the previous transfer so no signal is set twice
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
endmodule : axi_host_model

/* sim/tb_top.sv */
// Self-checking bench: register table rows, then sleep/wake and reset cases.
// Assumes the identity store block and the AXI4-Lite host model.
`timescale 1ns/1ps
module tb_top;
  import idstore_pkg::*;
  typedef struct packed {logic [11:0] a; logic wr; logic [31:0] d; logic [1:0] r;
    logic [31:0] e; logic [31:0] m;} row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic serial_activity = 1'b0;
  logic bus_activity = 1'b0;
  logic ignition_sense = 1'b1;
  logic [7:0] battery_dv = 8'h78;
  logic sleep_state;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] data;
  int n_errors = 0;
  int samples_checked = 0;
  row_t rows[$];
  initial forever #20 aclk = ~aclk;
  axi_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // Short silence so sleep entry fits the run
  identity_store_power_commands #(.SILENCE_CYCLES(20)) i_identity_store_power_commands (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_activity(serial_activity), .bus_activity(bus_activity),
    .ignition_sense(ignition_sense), .battery_dv(battery_dv), .sleep_state(sleep_state));
  function automatic row_t rw(logic [11:0] a, logic [31:0] d, logic [1:0] r);
    return '{a, 1'b1, d, r, 32'h0, 32'h0};
  endfunction : rw
  function automatic row_t rr(logic [11:0] a, logic [31:0] e, logic [31:0] m);
    return '{a, 1'b0, 32'h0, RESP_OKAY, e, m};
  endfunction : rr
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_word({30'h0, got}, {30'h0, exp});
  endtask : chk_resp
  task automatic chk_state(input logic exp);
    chk_word({31'h0, sleep_state}, {31'h0, exp});
  endtask : chk_state
  task automatic wait_sleep(input logic lvl, input int lim);
    int n;
    n = 0;
    while (sleep_state !== lvl && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_sleep
  task automatic end_of_test();
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (98000) @(posedge aclk);
    n_errors++;
    end_of_test();
  end
  initial begin
    rows.push_back(rr(A_CTRL, CTRL_RST, 32'h3F));
    rows.push_back(rr(A_SLEEP_V, {24'h0, SLEEP_V_RST}, 32'hFF));
    rows.push_back(rr(A_SLEEP_T, {16'h0, SLEEP_T_RST}, 32'hFFFF));
    rows.push_back(rr(A_WAKE_V, {24'h0, WAKE_V_RST}, 32'hFF));
    rows.push_back(rr(A_WAKE_T, {25'h0, WAKE_T_RST}, 32'h7F));
    rows.push_back(rr(A_HWADDR, {24'h0, NOT_SET_CHAR}, 32'hFF));
    rows.push_back(rw(A_SLEEP_V, 32'h9, RESP_SLVERR));
    rows.push_back(rw(A_SLEEP_V, 32'hFB, RESP_SLVERR));
    rows.push_back(rw(A_SLEEP_V, 32'hFA, RESP_OKAY));
    rows.push_back(rr(A_SLEEP_V, 32'hFA, 32'hFF));
    rows.push_back(rw(A_SLEEP_T, 32'h0, RESP_SLVERR));
    rows.push_back(rw(A_SLEEP_T, 32'hFFFF, RESP_OKAY));
    rows.push_back(rr(A_SLEEP_T, 32'hFFFF, 32'hFFFF));
    rows.push_back(rw(A_WAKE_V, 32'h0, RESP_SLVERR));
    rows.push_back(rw(A_WAKE_V, 32'h64, RESP_SLVERR));
    rows.push_back(rw(A_WAKE_T, 32'h65, RESP_SLVERR));
    rows.push_back(rw(A_WAKE_T, 32'h0, RESP_SLVERR));
    // Strings set while no protocol or wake sequence runs
    rows.push_back(rw(A_BANNER, 32'h41, RESP_OKAY));
    rows.push_back(rw(A_BANNER + 12'd184, 32'h7A, RESP_OKAY));
    rows.push_back(rw(A_BAN_LEN, 32'd48, RESP_SLVERR));
    rows.push_back(rw(A_BAN_LEN, 32'd47, RESP_OKAY));
    rows.push_back(rr(A_BANNER, 32'h41, 32'hFF));
    rows.push_back(rr(A_BANNER + 12'd184, 32'h7A, 32'hFF));
    rows.push_back(rw(A_DESC + 12'd8, 32'h20, RESP_OKAY));
    rows.push_back(rw(A_DSC_LEN, 32'd48, RESP_SLVERR));
    rows.push_back(rr(A_DESC + 12'd8, 32'h20, 32'hFF));
    rows.push_back(rw(A_UID, 32'h61, RESP_OKAY));
    rows.push_back(rw(A_UID + 12'd56, 32'h31, RESP_OKAY));
    rows.push_back(rw(A_UID_LEN, 32'd16, RESP_SLVERR));
    rows.push_back(rw(A_UID_LEN, 32'd15, RESP_OKAY));
    rows.push_back(rw(A_UID, 32'h62, RESP_SLVERR));
    rows.push_back(rw(A_UID_LEN, 32'd15, RESP_SLVERR));
    rows.push_back(rr(A_UID, 32'h61, 32'hFF));
    rows.push_back(rr(A_UID + 12'd56, 32'h31, 32'hFF));
    rows.push_back(rw(A_HWADDR, 32'h12, RESP_OKAY));
    rows.push_back(rw(A_HW_LEN, 32'd7, RESP_SLVERR));
    rows.push_back(rw(A_HW_LEN, 32'd6, RESP_OKAY));
    rows.push_back(rw(A_HW_LEN, 32'd12, RESP_SLVERR));
    rows.push_back(rw(A_HWADDR, 32'h99, RESP_SLVERR));
    rows.push_back(rr(A_HWADDR, 32'h12, 32'hFF));
    rows.push_back(rr(A_STATUS, 32'h0C, 32'h3F));
    rows.push_back(rr(A_VBAT, 32'h78, 32'hFF));
    // Few writes per location, far under the endurance limit
    rows.push_back(rw(12'h480, 32'h44332211, RESP_OKAY));
    rows.push_back(rr(12'h488, 32'h4433, 32'hFFFF));
    rows.push_back(rr(12'h480, 32'h44332211, 32'hFFFFFFFF));
    rows.push_back(rw(12'h7F0, 32'h04030201, RESP_OKAY));
    rows.push_back(rw(A_USER, 32'h08070605, RESP_OKAY));
    rows.push_back(rr(12'h7F8, 32'h06050403, 32'hFFFFFFFF));
    rows.push_back(rr(A_WR_CNT, 32'h3, 32'hFFFF));
    rows.push_back(rw(12'h034, 32'h0, RESP_SLVERR));
    rows.push_back(rw(A_PROTO, 32'h300, RESP_OKAY));
    rows.push_back(rr(A_PROTO, 32'h3, 32'h3));
    rows.push_back(rw(A_PROTO, 32'h0, RESP_OKAY));
    rows.push_back(rr(A_PROTO, 32'h0, 32'h3));
    // Wake switches only: no sleep source may fire during the table
    rows.push_back(rw(A_CTRL, 32'h38, RESP_OKAY));
    rows.push_back(rr(A_CTRL, 32'h38, 32'h3F));
    rows.push_back(rw(A_CTRL, 32'h0, RESP_OKAY));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) host.wr(rows[i].a, rows[i].d, 4'hF, resp);
      else host.rd(rows[i].a, data, resp);
      chk_resp(resp, rows[i].r);
      if (!rows[i].wr) chk_word(data & rows[i].m, rows[i].e);
    end
    host.rd(12'h034, data, resp);
    chk_resp(resp, RESP_SLVERR);
    chk_state(1'b0);
    host.wr(A_CTRL, 32'h09, 4'hF, resp);
    wait_sleep(1'b1, 80);
    chk_state(1'b1);
    serial_activity <= 1'b1;
    wait_sleep(1'b0, 20);
    chk_state(1'b0);
    host.wr(A_CTRL, 32'h12, 4'hF, resp);
    wait_sleep(1'b1, 80);
    chk_state(1'b1);
    bus_activity <= 1'b1;
    wait_sleep(1'b0, 20);
    chk_state(1'b0);
    host.wr(A_CTRL, 32'h24, 4'hF, resp);
    ignition_sense <= 1'b0;
    wait_sleep(1'b1, 40);
    chk_state(1'b1);
    ignition_sense <= 1'b1;
    wait_sleep(1'b0, 40);
    chk_state(1'b0);
    host.wr(A_WAKE_V, 32'h0A, 4'hF, resp);
    host.wr(A_WAKE_T, 32'h01, 4'hF, resp);
    host.wr(A_CTRL, 32'h04, 4'hF, resp);
    ignition_sense <= 1'b0;
    wait_sleep(1'b1, 40);
    chk_state(1'b1);
    // Pin high again: ignition wake is off, so only the drop may wake
    ignition_sense <= 1'b1;
    // Drop of 2.0 V split by a short recovery: neither part lasts 1 ms
    battery_dv <= 8'h64;
    repeat (15000) @(posedge aclk);
    battery_dv <= 8'h78;
    repeat (100) @(posedge aclk);
    battery_dv <= 8'h64;
    repeat (15000) @(posedge aclk);
    chk_state(1'b1);
    wait_sleep(1'b0, 60000);
    chk_state(1'b0);
    repeat (2) @(posedge aclk);
    chk_state(1'b0);
    battery_dv <= 8'h78;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk_state(1'b0);
    host.rd(A_CTRL, data, resp);
    chk_word(data & 32'h3F, CTRL_RST);
    end_of_test();
  end
endmodule : tb_top
